// ===== tb/avc_adc_model.sv
// Converter model answering the conditioner's sample requests
`timescale 1ns/100ps
module avc_adc_model
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [2:0] ch,
    input wire logic req,
    input wire logic [1:0] delay,
    input wire logic [127:0] levels,
    output logic valid_q,
    output logic signed [15:0] mv_q
);
    logic [1:0] cnt_q;
    // Data toggles between answers so a stale word is never mistaken
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            valid_q <= 1'b0;
            mv_q <= 16'h0000;
            cnt_q <= 2'h0;
        end
        else
        begin
            valid_q <= 1'b0;
            mv_q <= ~mv_q;
            if (req && !valid_q && cnt_q == delay)
            begin
                valid_q <= 1'b1;
                mv_q <= levels[16*ch+:16];
                cnt_q <= 2'h0;
            end
            else if (req && !valid_q)
                cnt_q <= cnt_q + 2'h1;
        end
    end
endmodule : avc_adc_model

// ===== tb/avc_channel_cond_monitor.sv
// Port-level checks for the voltage channel conditioner
`timescale 1ns/100ps
module avc_channel_cond_monitor
    import avc_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    input wire logic [2:0] ADC_CH,
    input wire logic ADC_REQ,
    input wire logic ADC_VALID,
    input wire logic [NCH*16-1:0] ANALOG_INPUT_TABLE,
    input wire logic [NCH*2-1:0] DISCRETE_INPUT_TABLE
);
    logic [NCH-1:0] at_min;
    logic [NCH-1:0] both;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    always_comb
    begin
        for (int g = 0; g < NCH; g++)
        begin
            at_min[g] = ANALOG_INPUT_TABLE[16*g+:16] == 16'h8000;
            both[g] = &DISCRETE_INPUT_TABLE[2*g+:2];
        end
    end
    sequence one_wait_s;
        AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
    endsequence
    wait_one_a: assert property ($rose(AVS_READ || AVS_WRITE) |-> one_wait_s)
        else $error("bus answer not after one wait state");
    idle_nowait_a: assert property (!(AVS_READ || AVS_WRITE)
        |-> !AVS_WAITREQUEST) else $error("waitrequest while idle");
    ch_hold_a: assert property (ADC_REQ && !ADC_VALID
        |=> ADC_REQ && $stable(ADC_CH)) else $error("request not held");
    req_drop_a: assert property (ADC_REQ && ADC_VALID |=> !ADC_REQ)
        else $error("request kept after sample");
    rdata_hold_a: assert property (!AVS_READ && !$past(AVS_READ)
        |=> $stable(AVS_READDATA)) else $error("read data moved");
    unmapped_zero_a: assert property (AVS_READ && !AVS_WAITREQUEST
        && AVS_ADDRESS inside {[8'h04:8'h0f]} |-> AVS_READDATA == 32'h0)
        else $error("unmapped read not zero");
    eu_floor_a: assert property (at_min == '0)
        else $error("result below floor");
    alarm_pair_a: assert property (both == '0)
        else $error("both alarms set");
endmodule : avc_channel_cond_monitor

// ===== tb/avc_channel_cond_tb.sv
// Self-checking bench for the voltage channel conditioner
`timescale 1ns/100ps
module avc_channel_cond_tb;
    import avc_pkg::*;
    localparam int P60 = 64;
    localparam int P50 = 80;
    logic SYS_CLK = 1'b0;
    logic RST_N = 1'b0;
    logic [7:0] AVS_ADDRESS = 8'h00;
    logic AVS_READ = 1'b0;
    logic AVS_WRITE = 1'b0;
    logic [31:0] AVS_WRITEDATA = 32'h0;
    logic [3:0] AVS_BYTEENABLE = 4'h0;
    logic [31:0] AVS_READDATA;
    logic AVS_WAITREQUEST;
    logic [2:0] ADC_CH;
    logic ADC_REQ;
    logic ADC_VALID;
    logic signed [15:0] ADC_MV;
    logic COMM_LOST = 1'b0;
    logic [127:0] ANALOG_INPUT_TABLE;
    logic [15:0] DISCRETE_INPUT_TABLE;
    logic [127:0] lvl = {16'h0, 16'h0320, 16'hfed4, 16'hec78, 16'h1388,
        16'h01f4, 16'hec78, 16'h04d2};
    logic [1:0] dly = 2'h0;
    logic req_prev = 1'b0;
    logic [31:0] rd;
    int mismatches = 0;
    int tests_run = 0;
    int cyc = 0;
    int last0 = 0;
    int gap0 = 0;
    int k0 = 0;
    int cnt_v [8];
    always #2 SYS_CLK = ~SYS_CLK;
    avc_channel_cond #(.PERIOD_60HZ(P60), .PERIOD_50HZ(P50)) uut (.SYS_CLK,
        .RST_N, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
        .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .ADC_CH, .ADC_REQ,
        .ADC_VALID, .ADC_MV, .COMM_LOST, .ANALOG_INPUT_TABLE,
        .DISCRETE_INPUT_TABLE);
    avc_adc_model adc (.clk(SYS_CLK), .rst_n(RST_N), .ch(ADC_CH),
        .req(ADC_REQ), .delay(dly), .levels(lvl), .valid_q(ADC_VALID),
        .mv_q(ADC_MV));
    always @(posedge SYS_CLK)
    begin
        cyc <= cyc + 1;
        req_prev <= ADC_REQ;
        if (ADC_VALID === 1'b1)
            cnt_v[ADC_CH] <= cnt_v[ADC_CH] + 1;
        if (ADC_REQ === 1'b1 && !req_prev && ADC_CH === 3'h0)
        begin
            gap0 <= cyc - last0;
            last0 <= cyc;
        end
    end
    task automatic complete_run();
        if (mismatches == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run
    task automatic chk(input string what, input logic [31:0] got,
        input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Design answers after one wait cycle; the count only guards against a hang
    task automatic bus(input logic we, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge SYS_CLK);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_BYTEENABLE <= 4'hf;
        AVS_WRITE <= we;
        AVS_READ <= !we;
        @(posedge SYS_CLK);
        while (AVS_WAITREQUEST !== 1'b0 && n < 50)
        begin
            @(posedge SYS_CLK);
            n++;
        end
        if (n == 50)
            chk("bus wait", 32'h1, 32'h0);
        rd = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
    endtask : bus
    task automatic w(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : w
    task automatic rc(input string what, input logic [7:0] a,
        input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(what, rd, exp);
    endtask : rc
    function automatic logic [7:0] ca(input int ch, input logic [2:0] s);
        return REG_CH_BASE + 8'(ch * REG_CH_STRIDE) + {5'h0, s};
    endfunction : ca
    function automatic logic [31:0] eu(input int g);
        return {16'h0, ANALOG_INPUT_TABLE[16*g+:16]};
    endfunction : eu
    task automatic cfg(input int ch, input logic [15:0] sl, sh);
        w(ca(ch, SLOT_EU_LO), 32'h0);
        w(ca(ch, SLOT_EU_HI), 32'h4e20);
        w(ca(ch, SLOT_SPAN_LO), {16'h0, sl});
        w(ca(ch, SLOT_HIGH_SPAN_POINT), {16'h0, sh});
    endtask : cfg
    task automatic wait_smp(input int ch, input int n);
        int t;
        int k;
        t = cnt_v[ch] + n;
        k = 0;
        while (cnt_v[ch] < t && k < 2000)
        begin
            @(posedge SYS_CLK);
            k++;
        end
        if (k == 2000)
            chk("sample wait", 32'h1, 32'h0);
        repeat (6) @(posedge SYS_CLK);
    endtask : wait_smp
    initial
    begin
        repeat (8) @(posedge SYS_CLK);
        RST_N <= 1'b1;
        rc("ctrl", REG_CTRL, 32'h0);
        rc("enable", REG_ENABLE, 32'hff);
        rc("range", ca(0, SLOT_RANGE), 32'h0);
        rc("eu_lo", ca(3, SLOT_EU_LO), 32'hffffd8f0);
        rc("unmapped", 8'h05, 32'h0);
        w(ca(7, SLOT_HIGH_SPAN_POINT), 32'h2711);
        rc("high_span_point", ca(7, SLOT_HIGH_SPAN_POINT), 32'h2710);
        w(ca(7, SLOT_ALM_LO), 32'h8000);
        rc("alm_lo", ca(7, SLOT_ALM_LO), 32'hffff8001);
        cfg(2, 16'h0, 16'h03e8);
        cfg(3, 16'hfc18, 16'h0);
        cfg(4, 16'h0, 16'h03e8);
        rc("span_lo", ca(3, SLOT_SPAN_LO), 32'hfffffc18);
        w(ca(5, SLOT_RANGE), 32'h1);
        w(ca(0, SLOT_ALM_LO), 32'h07d0);
        w(ca(0, SLOT_ALM_HI), 32'h0bb8);
        w(ca(1, SLOT_ALM_LO), 32'hdcd8);
        w(ca(1, SLOT_ALM_HI), 32'he890);
        wait_smp(7, 3);
        chk("eu0", eu(0), 32'h04d2);
        chk("eu1", eu(1), 32'hec78);
        chk("eu2", eu(2), 32'h2710);
        chk("eu3", eu(3), 32'h7fff);
        chk("eu4", eu(4), 32'h8001);
        chk("eu5", eu(5), 32'h0);
        chk("alm0", {30'h0, DISCRETE_INPUT_TABLE[1:0]}, 32'h1);
        chk("alm1", {30'h0, DISCRETE_INPUT_TABLE[3:2]}, 32'h2);
        rc("alarms", REG_ALARM, 32'h0201);
        rc("res4", REG_RES_BASE + 8'h04, 32'hffff8001);
        w(REG_CTRL, 32'h4);
        wait_smp(0, 3);
        chk("period60", 32'(gap0), 32'(P60));
        w(REG_CTRL, 32'h0);
        wait_smp(0, 3);
        chk("period50", 32'(gap0), 32'(P50));
        // Slow answers here so the sample count, not timing, sets the mean
        dly <= 2'h2;
        w(REG_CTRL, 32'h1);
        wait_smp(6, 8);
        lvl[96+:16] <= 16'h0640;
        wait_smp(6, 4);
        chk("filt8", eu(6), 32'h04b0);
        w(REG_CTRL, 32'h2);
        wait_smp(6, 4);
        chk("filt16", eu(6), 32'h04b0);
        chk("filt16 ch0", eu(0), 32'h04d2);
        dly <= 2'h0;
        w(REG_CTRL, 32'h18);
        COMM_LOST <= 1'b1;
        repeat (8) @(posedge SYS_CLK);
        lvl[0+:16] <= 16'hfc18;
        wait_smp(0, 2);
        chk("hold eu", eu(0), 32'h04d2);
        chk("hold alm", {30'h0, DISCRETE_INPUT_TABLE[1:0]}, 32'h1);
        rc("lost", REG_STATUS, 32'h1);
        w(REG_CTRL, 32'h0);
        repeat (6) @(posedge SYS_CLK);
        chk("zero eu", ANALOG_INPUT_TABLE[31:0], 32'h0);
        chk("zero alm", {16'h0, DISCRETE_INPUT_TABLE}, 32'h0);
        COMM_LOST <= 1'b0;
        wait_smp(0, 2);
        chk("eu0 new", eu(0), 32'hfc18);
        w(REG_ENABLE, 32'hfe);
        wait_smp(1, 1);
        k0 = cnt_v[0];
        wait_smp(1, 2);
        chk("eu0 off", eu(0), 32'h0);
        chk("alm0 off", {30'h0, DISCRETE_INPUT_TABLE[1:0]}, 32'h0);
        chk("skip", 32'(cnt_v[0]), 32'(k0));
        complete_run();
    end
    initial
    begin
        repeat (20000) @(posedge SYS_CLK);
        mismatches++;
        complete_run();
    end
endmodule : avc_channel_cond_tb
bind avc_channel_cond avc_channel_cond_monitor mon (.SYS_CLK, .RST_N,
    .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_READDATA, .AVS_WAITREQUEST,
    .ADC_CH, .ADC_REQ, .ADC_VALID, .ANALOG_INPUT_TABLE,
    .DISCRETE_INPUT_TABLE);

// ===== verilog/avc_channel_cond.sv
// Eight-channel voltage input conditioner with Avalon-MM registers
//
// The Avalon-MM interface to the registers and the register offsets were decided locally.
`timescale 1ns/100ps
// What this block does
// - Comm loss: hold or zero inputs per type
// - No filter: report latest sample
// - Short filter: average latest eight samples
// - Long filter: average latest sixteen samples
// - Filter applies to enabled channels only
// - Higher mains setting: 1.04 ms per channel
// - Lower mains setting: 1.25 ms per channel
// - Disabled channel skipped, reports zero
// - Range one: bipolar ten volts one-to-one
// - Range two: unipolar ten volts one-to-one
// - Reset range is bipolar ten volts
// - Linear scaling through two configured points
// - Default scaling gives minus to plus 10000
// - Clamp low results to -32767
// - Clamp high results to 32767
// - Span points accepted within plus/minus 10000
// - Alarm limits within plus/minus 32767 per channel
module avc_channel_cond
    import avc_pkg::*;
#(
    parameter int PERIOD_60HZ = PERIOD_60HZ_CYC,
    parameter int PERIOD_50HZ = PERIOD_50HZ_CYC
)
(
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    output logic [2:0] ADC_CH,
    output logic ADC_REQ,
    input wire logic ADC_VALID,
    input wire logic signed [15:0] ADC_MV,
    input wire logic COMM_LOST,
    output logic [NCH*16-1:0] ANALOG_INPUT_TABLE,
    output logic [NCH*2-1:0] DISCRETE_INPUT_TABLE
);
    logic [31:0] ctrl_q;
    logic [7:0] enable_q;
    ch_cfg_t cfg_q [NCH];
    logic signed [15:0] eu_q [NCH];
    logic [NCH-1:0] alm_lo_q;
    logic [NCH-1:0] alm_hi_q;
    logic [15:0] aout_q [NCH];
    logic [NCH*2-1:0] dout_q;
    logic ack_q;
    logic [31:0] rdata_q;

    logic [31:0] tick_q;
    logic [2:0] scan_q;
    logic busy_q;
    logic [2:0] lost_sync_q;
    logic lost_q;

    filt_t filt;
    logic freq_60;
    logic hold_ai;
    logic hold_di;
    logic [31:0] period;
    logic tick_done;
    logic [7:0] en_next;
    logic [2:0] next_ch;
    logic any_en;
    sample_t smp;
    logic avg_valid;
    logic [2:0] avg_ch;
    logic signed [15:0] avg_mv;
    logic sc_valid;
    logic [2:0] sc_ch;
    logic signed [15:0] sc_eu;

    logic req;
    logic wr_ctrl;
    logic wr_enable;
    logic in_ch_win;
    logic in_res_win;
    logic [7:0] ch_off;
    logic [7:0] res_off;
    logic [2:0] win_ch;
    logic [2:0] win_slot;
    logic [2:0] res_ch;
    logic signed [15:0] wr_val;
    logic span_ok;
    logic alm_ok;
    logic [31:0] rd_mux;

    assign filt = filt_t'(ctrl_q[CTRL_FILT_LSB +: 2]);
    assign freq_60 = ctrl_q[CTRL_FREQ_BIT];
    assign hold_ai = ctrl_q[CTRL_HOLD_AI_BIT];
    assign hold_di = ctrl_q[CTRL_HOLD_I_BIT];
    assign period = freq_60 ? 32'(PERIOD_60HZ) : 32'(PERIOD_50HZ);

    // Each enabled channel is visited once per period, so the slot length
    // is the period divided by the number of enabled channels
    // Integer division can leave a full scan a few cycles short
    logic [3:0] n_en;
    always_comb
    begin
        n_en = 4'h0;
        for (int c = 0; c < NCH; c++)
            n_en = n_en + 4'(enable_q[c]);
    end
    assign tick_done = (n_en != 4'h0) && (tick_q >= (period / 32'(n_en)) - 1);
    assign any_en = |enable_q;

    // Next enabled channel after the current one, wrapping round
    always_comb
    begin
        next_ch = scan_q;
        en_next = 8'({enable_q, enable_q} >>
            (4'(scan_q) + 4'h1));
        for (int k = NCH - 1; k >= 0; k--)
            if (en_next[k])
                next_ch = 3'(4'(scan_q) + 4'h1 + 4'(k));
    end

    assign ADC_CH = scan_q;
    assign ADC_REQ = busy_q;
    // A sample for a channel disabled in flight is dropped
    assign smp = '{
        valid: ADC_VALID && busy_q && enable_q[scan_q],
        ch: scan_q,
        mv: ADC_MV
    };

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            tick_q <= 32'h0;
            scan_q <= 3'h0;
            busy_q <= 1'b0;
        end
        else if (!any_en)
        begin
            tick_q <= 32'h0;
            busy_q <= 1'b0;
        end
        else
        begin
            tick_q <= tick_done ? 32'h0 : tick_q + 32'h1;
            if (tick_done)
            begin
                scan_q <= next_ch;
                busy_q <= 1'b1;
            end
            else if (ADC_VALID)
                busy_q <= 1'b0;
        end
    end

    avc_filter u_filter
    (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .smp(smp),
        .mode(filt),
        .avg_valid(avg_valid),
        .avg_ch(avg_ch),
        .avg_mv(avg_mv)
    );

    avc_scaler u_scaler
    (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .in_valid(avg_valid),
        .in_ch(avg_ch),
        .in_mv(avg_mv),
        .cfg(cfg_q[avg_ch]),
        .out_valid(sc_valid),
        .out_ch(sc_ch),
        .out_eu(sc_eu)
    );

    // Communication loss comes from outside this clock's domain
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            lost_sync_q <= 3'h0;
            lost_q <= 1'b0;
        end
        else
        begin
            lost_sync_q <= {lost_sync_q[1:0], COMM_LOST};
            if (lost_sync_q[2] == lost_sync_q[1])
                lost_q <= lost_sync_q[1];
        end
    end

    // Bus decode: one wait cycle, then a registered answer
    assign req = (AVS_READ || AVS_WRITE) && !ack_q;
    assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack_q;
    assign in_ch_win = AVS_ADDRESS >= REG_CH_BASE &&
                       AVS_ADDRESS < REG_CH_BASE + 8'(NCH * REG_CH_STRIDE);
    assign in_res_win = AVS_ADDRESS >= REG_RES_BASE &&
                        AVS_ADDRESS < REG_RES_BASE + 8'(NCH);
    assign ch_off = AVS_ADDRESS - REG_CH_BASE;
    assign res_off = AVS_ADDRESS - REG_RES_BASE;
    assign win_ch = ch_off[5:3];
    assign win_slot = ch_off[2:0];
    assign res_ch = res_off[2:0];
    assign wr_val = AVS_WRITEDATA[15:0];
    // Writes land at the edge where waitrequest is low
    assign wr_ctrl = ack_q && AVS_WRITE && AVS_ADDRESS == REG_CTRL &&
                     AVS_BYTEENABLE[0];
    assign wr_enable = ack_q && AVS_WRITE && AVS_ADDRESS == REG_ENABLE &&
                       AVS_BYTEENABLE[0];
    assign span_ok = wr_val >= SPAN_MIN && wr_val <= SPAN_MAX;
    assign alm_ok = wr_val >= EU_MIN;

    always_comb
    begin
        rd_mux = 32'h0;
        if (AVS_ADDRESS == REG_CTRL)
            rd_mux = ctrl_q;
        else if (AVS_ADDRESS == REG_ENABLE)
            rd_mux = {24'h0, enable_q};
        else if (AVS_ADDRESS == REG_STATUS)
            rd_mux = {31'h0, lost_q};
        else if (AVS_ADDRESS == REG_ALARM)
            rd_mux = {16'h0, alm_hi_q, alm_lo_q};
        else if (in_ch_win && win_slot == SLOT_RANGE)
            rd_mux = {31'h0, cfg_q[win_ch].range};
        else if (in_ch_win && win_slot == SLOT_EU_LO)
            rd_mux = 32'(cfg_q[win_ch].eu_lo);
        else if (in_ch_win && win_slot == SLOT_EU_HI)
            rd_mux = 32'(cfg_q[win_ch].eu_hi);
        else if (in_ch_win && win_slot == SLOT_SPAN_LO)
            rd_mux = 32'(cfg_q[win_ch].span_lo);
        else if (in_ch_win && win_slot == SLOT_HIGH_SPAN_POINT)
            rd_mux = 32'(cfg_q[win_ch].high_span_point);
        else if (in_ch_win && win_slot == SLOT_ALM_LO)
            rd_mux = 32'(cfg_q[win_ch].alm_lo);
        else if (in_ch_win && win_slot == SLOT_ALM_HI)
            rd_mux = 32'(cfg_q[win_ch].alm_hi);
        else if (in_res_win)
            rd_mux = 32'($signed(aout_q[res_ch]));
        else
            rd_mux = 32'h0;
    end

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0;
            ctrl_q <= CTRL_RESET;
            enable_q <= ENABLE_RESET;
        end
        else
        begin
            ack_q <= req;
            if (req && AVS_READ)
                rdata_q <= rd_mux;
            if (wr_ctrl)
                ctrl_q <= {27'h0, AVS_WRITEDATA[4:0]};
            if (wr_enable)
                enable_q <= AVS_WRITEDATA[7:0];
        end
    end
    assign AVS_READDATA = rdata_q;

    // Per-channel configuration, results and alarms
    genvar g;
    generate
        for (g = 0; g < NCH; g++)
        begin : g_ch
            logic wr_here;
            assign wr_here = ack_q && AVS_WRITE && in_ch_win &&
                             win_ch == 3'(g) && &AVS_BYTEENABLE[1:0];

            always_ff @(posedge SYS_CLK or negedge RST_N)
            begin
                if (!RST_N)
                begin
                    cfg_q[g] <= CH_CFG_RESET;
                    eu_q[g] <= 16'sh0000;
                    alm_lo_q[g] <= 1'b0;
                    alm_hi_q[g] <= 1'b0;
                    aout_q[g] <= 16'h0;
                    dout_q[2*g +: 2] <= 2'h0;
                end
                else
                begin
                    if (wr_here && win_slot == SLOT_RANGE)
                        cfg_q[g].range <= range_t'(AVS_WRITEDATA[0]);
                    if (wr_here && win_slot == SLOT_EU_LO && alm_ok)
                        cfg_q[g].eu_lo <= wr_val;
                    if (wr_here && win_slot == SLOT_EU_HI && alm_ok)
                        cfg_q[g].eu_hi <= wr_val;
                    if (wr_here && win_slot == SLOT_SPAN_LO && span_ok)
                        cfg_q[g].span_lo <= wr_val;
                    if (wr_here && win_slot == SLOT_HIGH_SPAN_POINT && span_ok)
                        cfg_q[g].high_span_point <= wr_val;
                    if (wr_here && win_slot == SLOT_ALM_LO && alm_ok)
                        cfg_q[g].alm_lo <= wr_val;
                    if (wr_here && win_slot == SLOT_ALM_HI && alm_ok)
                        cfg_q[g].alm_hi <= wr_val;
                    if (!enable_q[g])
                    begin
                        eu_q[g] <= 16'sh0000;
                        alm_lo_q[g] <= 1'b0;
                        alm_hi_q[g] <= 1'b0;
                    end
                    else if (sc_valid && sc_ch == 3'(g))
                    begin
                        eu_q[g] <= sc_eu;
                        alm_lo_q[g] <= sc_eu < cfg_q[g].alm_lo;
                        alm_hi_q[g] <= sc_eu > cfg_q[g].alm_hi;
                    end
                    // Outputs to the interface unit: hold or zero on loss
                    if (!lost_q)
                    begin
                        aout_q[g] <= enable_q[g] ? eu_q[g] : 16'h0;
                        dout_q[2*g +: 2] <= {alm_hi_q[g], alm_lo_q[g]};
                    end
                    else
                    begin
                        if (!hold_ai)
                            aout_q[g] <= 16'h0;
                        if (!hold_di)
                            dout_q[2*g +: 2] <= 2'h0;
                    end
                end
            end
            assign ANALOG_INPUT_TABLE[16*g +: 16] = aout_q[g];
        end
    endgenerate
    assign DISCRETE_INPUT_TABLE = dout_q;
endmodule : avc_channel_cond

// ===== verilog/avc_filter.sv
// Moving-average history for all channels
`timescale 1ns/100ps
module avc_filter
    import avc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire sample_t smp,
    input wire filt_t mode,
    output logic avg_valid,
    output logic [2:0] avg_ch,
    output logic signed [15:0] avg_mv
);
    logic signed [15:0] hist_q [NCH][HIST_DEPTH];
    logic [3:0] wp_q [NCH];
    logic signed [19:0] sum8;
    logic signed [19:0] sum16;
    logic signed [19:0] res;

    // Sum includes the incoming sample so the result is fresh
    always_comb
    begin
        sum8 = 20'(smp.mv);
        sum16 = 20'(smp.mv);
        for (int k = 1; k < HIST_DEPTH; k++)
        begin
            if (k < 8)
                sum8 = sum8 + 20'(hist_q[smp.ch][4'(wp_q[smp.ch] - 4'(k))]);
            sum16 = sum16 + 20'(hist_q[smp.ch][4'(wp_q[smp.ch] - 4'(k))]);
        end
    end

    assign res = (mode == FILT_8) ? (sum8 >>> SHIFT_8) :
                 (mode == FILT_16) ? (sum16 >>> SHIFT_16) :
                 20'(smp.mv);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int c = 0; c < NCH; c++)
            begin
                wp_q[c] <= 4'h0;
                for (int k = 0; k < HIST_DEPTH; k++)
                    hist_q[c][k] <= 16'sh0000;
            end
            avg_valid <= 1'b0;
            avg_ch <= 3'h0;
            avg_mv <= 16'sh0000;
        end
        else
        begin
            avg_valid <= smp.valid;
            if (smp.valid)
            begin
                hist_q[smp.ch][wp_q[smp.ch]] <= smp.mv;
                wp_q[smp.ch] <= wp_q[smp.ch] + 4'h1;
                avg_ch <= smp.ch;
                avg_mv <= res[15:0];
            end
        end
    end
endmodule : avc_filter

// ===== verilog/avc_pkg.sv
// Shared constants and types for the analog voltage channel conditioner
package avc_pkg;
    localparam int NCH = 8;
    localparam int CLK_MHZ = 250;
    // Per-channel sample periods in nanoseconds, then in clock cycles
    localparam int PERIOD_60HZ_NS = 1040000;
    localparam int PERIOD_50HZ_NS = 1250000;
    localparam int PERIOD_60HZ_CYC = PERIOD_60HZ_NS * CLK_MHZ / 1000;
    localparam int PERIOD_50HZ_CYC = PERIOD_50HZ_NS * CLK_MHZ / 1000;
    localparam int HIST_DEPTH = 16;
    localparam int SHIFT_8 = 3;
    localparam int SHIFT_16 = 4;
    localparam logic signed [15:0] EU_MAX = 16'sh7fff;
    localparam logic signed [15:0] EU_MIN = -16'sh7fff;
    localparam logic signed [15:0] SPAN_MAX = 16'sh2710;
    localparam logic signed [15:0] SPAN_MIN = -16'sh2710;
    localparam logic signed [15:0] ZERO16 = 16'sh0000;

    // Register map (word addresses on Avalon-MM, byte address = 4 * index)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ENABLE = 8'h01;
    localparam logic [7:0] REG_STATUS = 8'h02;
    localparam logic [7:0] REG_ALARM = 8'h03;
    localparam logic [7:0] REG_CH_BASE = 8'h10;
    localparam logic [7:0] REG_RES_BASE = 8'h60;
    localparam int REG_CH_STRIDE = 8;
    // Per-channel slots within a stride
    localparam logic [2:0] SLOT_RANGE = 3'h0;
    localparam logic [2:0] SLOT_EU_LO = 3'h1;
    localparam logic [2:0] SLOT_EU_HI = 3'h2;
    localparam logic [2:0] SLOT_SPAN_LO = 3'h3;
    localparam logic [2:0] SLOT_HIGH_SPAN_POINT = 3'h4;
    localparam logic [2:0] SLOT_ALM_LO = 3'h5;
    localparam logic [2:0] SLOT_ALM_HI = 3'h6;
    // Control field positions
    localparam int CTRL_FILT_LSB = 0;
    localparam int CTRL_FREQ_BIT = 2;
    localparam int CTRL_HOLD_AI_BIT = 3;
    localparam int CTRL_HOLD_I_BIT = 4;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [7:0] ENABLE_RESET = 8'hff;

    typedef enum logic [1:0]
    {
        FILT_NONE = 2'b00,
        FILT_8 = 2'b01,
        FILT_16 = 2'b10
    } filt_t;

    typedef enum logic
    {
        RANGE_BIPOLAR = 1'b0,
        RANGE_UNIPOLAR = 1'b1
    } range_t;

    typedef struct packed
    {
        range_t range;
        logic signed [15:0] eu_lo;
        logic signed [15:0] eu_hi;
        logic signed [15:0] span_lo;
        logic signed [15:0] high_span_point;
        logic signed [15:0] alm_lo;
        logic signed [15:0] alm_hi;
    } ch_cfg_t;

    localparam ch_cfg_t CH_CFG_RESET = '{
        range: RANGE_BIPOLAR,
        eu_lo: -16'sh2710,
        eu_hi: 16'sh2710,
        span_lo: -16'sh2710,
        high_span_point: 16'sh2710,
        alm_lo: -16'sh7fff,
        alm_hi: 16'sh7fff
    };

    typedef struct packed
    {
        logic valid;
        logic [2:0] ch;
        logic signed [15:0] mv;
    } sample_t;
endpackage : avc_pkg

// ===== verilog/avc_scaler.sv
// Two-point linear scaling with saturation
`timescale 1ns/100ps
module avc_scaler
    import avc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic [2:0] in_ch,
    input wire logic signed [15:0] in_mv,
    input wire ch_cfg_t cfg,
    output logic out_valid,
    output logic [2:0] out_ch,
    output logic signed [15:0] out_eu
);
    logic signed [15:0] mv_r;
    logic signed [17:0] dx;
    logic signed [17:0] dspan;
    logic signed [17:0] deu;
    logic signed [35:0] prod;
    logic signed [35:0] quo;
    logic signed [36:0] eu_w;

    // Unipolar range cannot go below zero millivolts
    assign mv_r = (cfg.range == RANGE_UNIPOLAR && in_mv < ZERO16) ?
                  ZERO16 : in_mv;
    assign dx = 18'(mv_r) - 18'(cfg.span_lo);
    assign dspan = 18'(cfg.high_span_point) - 18'(cfg.span_lo);
    assign deu = 18'(cfg.eu_hi) - 18'(cfg.eu_lo);
    assign prod = 36'(dx) * 36'(deu);
    // Equal span points would divide by zero; report the low point then
    assign quo = (dspan == 18'sh0) ? 36'sh0 : prod / 36'(dspan);
    assign eu_w = 37'(quo) + 37'(cfg.eu_lo);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_valid <= 1'b0;
            out_ch <= 3'h0;
            out_eu <= 16'sh0000;
        end
        else
        begin
            out_valid <= in_valid;
            out_ch <= in_ch;
            if (eu_w < 37'(EU_MIN))
                out_eu <= EU_MIN;
            else if (eu_w > 37'(EU_MAX))
                out_eu <= EU_MAX;
            else
                out_eu <= eu_w[15:0];
        end
    end
endmodule : avc_scaler
